//--- rtl/pmc_pkg.sv
// Constants shared by the power-mode controller and its clock-loss timer.
// Assumes a 25 MHz system clock and a single AHB-Lite slave port.
`default_nettype none

package pmc_pkg;

	// ***************************************************
	// Register map (byte addresses on AHB, one word each)
	// ***************************************************
	// Printed register index; the byte address is four times it
	localparam logic [7:0] POWER_CONTROL_INDEX = 8'h87;
	localparam logic [11:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_INDEX, 2'h0};
	localparam logic [7:0] STATUS_INDEX = 8'h88;
	localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
	localparam logic [7:0] CONFIG_INDEX = 8'h89;
	localparam logic [11:0] CONFIG_ADDR = {2'h0, CONFIG_INDEX, 2'h0};

	// ***************************************************
	// Field positions and reset values
	// ***************************************************
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;

	localparam int WDOG_EN_BIT = 0;
	localparam int MCD_EN_BIT = 1;
	localparam int SUSPEND_BIT = 2;
	localparam logic [7:0] CONFIG_RESET = 8'h01;

	localparam int ST_MODE_LSB = 0;
	localparam int ST_MCD_RST_BIT = 2;
	localparam int ST_WDOG_RST_BIT = 3;
	localparam int ST_EXT_RST_BIT = 4;

	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_FREQ_KHZ = 25000;
	localparam int MCD_TIMEOUT_US = 100;
	// Longest time: round down, never below one cycle
	localparam int MCD_CYCLES_RAW = (MCD_TIMEOUT_US * CLK_FREQ_KHZ) / 1000;
	localparam int MCD_CYCLES = (MCD_CYCLES_RAW < 1) ? 1 : MCD_CYCLES_RAW;
	localparam logic [11:0] MCD_LIMIT = 12'(MCD_CYCLES - 1);

	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_STOP,
		PMC_SUSPEND
	} pmc_mode_e;

endpackage : pmc_pkg

`default_nettype wire

//--- rtl/pmc_clock_loss.sv
// Missing-clock timer: fires a one-cycle reset request when no clock
// activity marker has been seen for the timeout while enabled.
// Assumes clk_seen is a synchronous pulse from the oscillator monitor.
`default_nettype none

module pmc_clock_loss (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic clk_seen,
	output logic fire
);

	logic [11:0] count;
	wire logic at_limit;

	assign at_limit = (count == pmc_pkg::MCD_LIMIT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 12'h000;
			fire <= 1'b0;
		end else begin
			fire <= enable && !clk_seen && at_limit;
			if (!enable || clk_seen || at_limit) begin
				count <= 12'h000;
			end else begin
				count <= count + 12'h001;
			end
		end
	end

	// ***************************************************
	// Checks
	// ***************************************************
	// timeout reset
	mcd_fire_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire |-> $past(at_limit) && $past(enable))
		else $error("clock-loss fire without full timeout");

endmodule : pmc_clock_loss

`default_nettype wire

//--- rtl/pmc_power_ctrl.sv
// Power-mode controller: power_control register on AHB-Lite, Idle, Stop
// and Suspend sequencing, and reset handling that ends every mode.
// Assumes the CPU pulses cpu_instr_done as each instruction retires and
// that irq_pending already carries only enabled interrupts.
//
// Summary of operation
// - Writing the idle bit halts the CPU once the writing instruction finishes.
// - In idle, state is kept and clocks and peripherals keep running.
// - An enabled interrupt during idle clears the idle bit and resumes.
// - After interrupt service, execution continues at the instruction after.
// - A reset during idle runs the reset sequence, fetching from zero.
// - An enabled watchdog keeps counting in idle and may reset it.
// - Writing the stop bit enters stop once the writing instruction completes.
// - Stop halts oscillator, CPU and digital peripherals, not the external oscillator.
// - In stop all interrupts and timers are held, except clock-loss detection.
// - Only a reset ends stop, then execution starts at address zero.
// - An enabled clock-loss detector resets the device, ending stop.
// - Suspend stops the internal oscillator until a wake event.
`default_nettype none

module pmc_power_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cpu_instr_done,
	input wire logic irq_pending,
	input wire logic ext_reset,
	input wire logic watchdog_reset,
	input wire logic clk_seen,
	input wire logic wake_event,
	output logic cpu_halt,
	output logic idle_wake,
	output logic periph_halt,
	output logic irq_timer_hold,
	output logic osc_stop,
	output logic watchdog_run,
	output logic mcd_run,
	output logic reset_req,
	output logic [15:0] reset_vector
);

	// ***************************************************
	// Bus slave
	// ***************************************************
	logic dp_write;
	logic [11:0] dp_addr;
	logic [7:0] power_control;
	logic [7:0] config_reg;
	logic [4:0] status_flags;
	pmc_pkg::pmc_mode_e mode;
	pmc_pkg::pmc_mode_e next_mode;

	wire logic addr_phase;
	wire logic wr_power;
	wire logic wr_config;
	wire logic mcd_fire;
	wire logic any_reset;
	wire logic [7:0] power_readback;
	wire logic [7:0] status_word;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Transfer size is not checked: software only ever moves whole words here
	assign addr_phase = hsel && hready && htrans[1];
	assign wr_power = dp_write && (dp_addr == pmc_pkg::POWER_CONTROL_ADDR);
	assign wr_config = dp_write && (dp_addr == pmc_pkg::CONFIG_ADDR);

	assign power_readback = {power_control[7:1], 1'b0};
	assign status_word = {3'h0, status_flags[4:2], mode};

	// Unmapped addresses read zero and ignore writes
	assign hrdata = (dp_addr == pmc_pkg::POWER_CONTROL_ADDR) ? {24'h000000, power_readback} :
		(dp_addr == pmc_pkg::STATUS_ADDR) ? {24'h000000, status_word} :
		(dp_addr == pmc_pkg::CONFIG_ADDR) ? {24'h000000, config_reg} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 12'h000;
		end else begin
			dp_write <= addr_phase && hwrite;
			if (addr_phase) begin
				dp_addr <= haddr[11:0];
			end
		end
	end

	// ***************************************************
	// Reset sources
	// ***************************************************
	pmc_clock_loss u_clock_loss (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(config_reg[pmc_pkg::MCD_EN_BIT]),
		.clk_seen(clk_seen),
		.fire(mcd_fire)
	);

	assign any_reset = ext_reset || watchdog_reset || mcd_fire;

	// ***************************************************
	// Mode sequencing
	// ***************************************************
	// Stop wins when both select bits are written together
	always_comb begin
		next_mode = mode;
		unique case (mode)
			pmc_pkg::PMC_RUN: begin
				if (cpu_instr_done && power_control[pmc_pkg::STOP_BIT]) begin
					next_mode = pmc_pkg::PMC_STOP;
				end else if (cpu_instr_done && power_control[pmc_pkg::IDLE_BIT]) begin
					next_mode = pmc_pkg::PMC_IDLE;
				end else if (config_reg[pmc_pkg::SUSPEND_BIT]) begin
					next_mode = pmc_pkg::PMC_SUSPEND;
				end
			end
			pmc_pkg::PMC_IDLE: begin
				if (irq_pending) begin
					next_mode = pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_STOP: next_mode = pmc_pkg::PMC_STOP;
			pmc_pkg::PMC_SUSPEND: begin
				if (wake_event) begin
					next_mode = pmc_pkg::PMC_RUN;
				end
			end
		endcase
		if (any_reset) begin
			next_mode = pmc_pkg::PMC_RUN;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= pmc_pkg::PMC_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// ***************************************************
	// Registers
	// ***************************************************
	// wake clears idle bit
	// A software write in the wake cycle wins over the hardware clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_control <= pmc_pkg::POWER_CONTROL_RESET;
		end else if (any_reset) begin
			power_control <= pmc_pkg::POWER_CONTROL_RESET;
		end else if (wr_power) begin
			power_control <= hwdata[7:0];
		end else if (mode == pmc_pkg::PMC_IDLE && irq_pending) begin
			power_control[pmc_pkg::IDLE_BIT] <= 1'b0;
		end
	end

	// Suspend request bit self-clears once the mode is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_reg <= pmc_pkg::CONFIG_RESET;
		end else if (wr_config) begin
			config_reg <= hwdata[7:0];
		end else if (next_mode == pmc_pkg::PMC_SUSPEND || any_reset) begin
			config_reg[pmc_pkg::SUSPEND_BIT] <= 1'b0;
		end
	end

	// Cause of the last internal or external reset, kept across it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_flags <= 5'h00;
		end else if (any_reset) begin
			status_flags <= {ext_reset, watchdog_reset, mcd_fire, 2'h0};
		end
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_req <= 1'b0;
			idle_wake <= 1'b0;
		end else begin
			reset_req <= any_reset;
			idle_wake <= (mode == pmc_pkg::PMC_IDLE) && irq_pending && !any_reset;
		end
	end

	assign reset_vector = pmc_pkg::RESET_VECTOR;
	assign cpu_halt = (mode != pmc_pkg::PMC_RUN);
	assign periph_halt = (mode == pmc_pkg::PMC_STOP);
	assign irq_timer_hold = (mode == pmc_pkg::PMC_STOP);
	assign osc_stop = (mode == pmc_pkg::PMC_STOP) || (mode == pmc_pkg::PMC_SUSPEND);
	assign watchdog_run = config_reg[pmc_pkg::WDOG_EN_BIT] && (mode != pmc_pkg::PMC_STOP);
	assign mcd_run = config_reg[pmc_pkg::MCD_EN_BIT];

	// ***************************************************
	// Checks
	// ***************************************************
	sequence s_idle_armed;
		(mode == pmc_pkg::PMC_RUN) && power_control[pmc_pkg::IDLE_BIT]
			&& !power_control[pmc_pkg::STOP_BIT] && cpu_instr_done && !any_reset;
	endsequence

	sequence s_idle_woken;
		(mode == pmc_pkg::PMC_IDLE) && irq_pending && !any_reset;
	endsequence

	idle_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_idle_armed |=> (mode == pmc_pkg::PMC_IDLE) && cpu_halt)
		else $error("idle not entered after instruction");

	idle_keeps_clocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_IDLE) |-> !osc_stop && !periph_halt && !irq_timer_hold)
		else $error("idle stopped clocks or peripherals");

	idle_wake_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_idle_woken |=> (mode == pmc_pkg::PMC_RUN) && !power_control[pmc_pkg::IDLE_BIT])
		else $error("interrupt did not end idle");

	wake_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_idle_woken |=> idle_wake ##1 !idle_wake)
		else $error("resume pulse missing or stretched");

	reset_ends_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		any_reset |=> reset_req && (mode == pmc_pkg::PMC_RUN)
			&& (power_control == pmc_pkg::POWER_CONTROL_RESET))
		else $error("reset did not end power mode");

	watchdog_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_IDLE) |-> watchdog_run == config_reg[pmc_pkg::WDOG_EN_BIT])
		else $error("watchdog halted in idle");

	stop_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_RUN) && power_control[pmc_pkg::STOP_BIT] && cpu_instr_done
			&& !any_reset |=> periph_halt && osc_stop && cpu_halt)
		else $error("stop not entered after instruction");

	stop_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_STOP) && !any_reset |=> (mode == pmc_pkg::PMC_STOP))
		else $error("stop left without reset");

	stop_holds_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_STOP) |-> irq_timer_hold && !watchdog_run
			&& (mcd_run == config_reg[pmc_pkg::MCD_EN_BIT]))
		else $error("stop left timers or detector wrong");

	idle_reads_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(dp_addr == pmc_pkg::POWER_CONTROL_ADDR) |-> !hrdata[pmc_pkg::IDLE_BIT])
		else $error("idle bit read back as one");

	suspend_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_SUSPEND) && !wake_event && !any_reset |=> osc_stop)
		else $error("oscillator restarted without wake");

	// Suspend is entered from a request and left on a wake, one edge each
	sequence s_suspend_req;
		(mode == pmc_pkg::PMC_RUN) && config_reg[pmc_pkg::SUSPEND_BIT] && !cpu_instr_done
			&& !wr_config && !any_reset;
	endsequence

	sequence s_suspend_woken;
		(mode == pmc_pkg::PMC_SUSPEND) && wake_event && !any_reset;
	endsequence

	suspend_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_suspend_req |=> (mode == pmc_pkg::PMC_SUSPEND) && osc_stop
			&& !config_reg[pmc_pkg::SUSPEND_BIT])
		else $error("suspend not entered on request");

	suspend_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_suspend_woken |=> (mode == pmc_pkg::PMC_RUN) && !osc_stop && !cpu_halt)
		else $error("wake did not end suspend");

	stop_halts_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_STOP) |-> cpu_halt && periph_halt && osc_stop)
		else $error("stop left a clock or core running");

	run_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_RUN) |-> !cpu_halt && !periph_halt && !osc_stop && !irq_timer_hold)
		else $error("halt output set while running");

	idle_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_IDLE) && !irq_pending && !any_reset
			|=> (mode == pmc_pkg::PMC_IDLE) && cpu_halt)
		else $error("idle left without interrupt or reset");

	idle_state_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_IDLE) && !irq_pending && !any_reset && !wr_power && !wr_config
			|=> $stable(power_control) && $stable(config_reg))
		else $error("register changed during idle");

	wake_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
		idle_wake |-> $past(mode == pmc_pkg::PMC_IDLE) && $past(irq_pending))
		else $error("resume pulse without idle interrupt");

	stop_priority_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_RUN) && power_control[pmc_pkg::STOP_BIT]
			&& power_control[pmc_pkg::IDLE_BIT] && cpu_instr_done && !any_reset
			|=> (mode == pmc_pkg::PMC_STOP))
		else $error("stop did not win over idle");

	reset_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		reset_req |-> $past(any_reset))
		else $error("reset request without a source");

	reset_vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
		reset_req |-> (reset_vector == pmc_pkg::RESET_VECTOR))
		else $error("reset fetch address not zero");

	mcd_ends_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == pmc_pkg::PMC_STOP) && mcd_fire
			|=> (mode == pmc_pkg::PMC_RUN) && reset_req && status_flags[pmc_pkg::ST_MCD_RST_BIT])
		else $error("clock loss did not end stop");

	ext_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_reset |=> reset_req && status_flags[pmc_pkg::ST_EXT_RST_BIT])
		else $error("external reset not recorded");

	// Zero wait states, always OKAY
	bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("bus slave stalled or errored");

endmodule : pmc_power_ctrl

`default_nettype wire

//--- verification/pmc_cpu_model.sv
// Partner model: the core's instruction retirement, interrupt line and PC.
// Assumes the controller's halt and reset outputs run on the same clock.
`default_nettype none

module pmc_cpu_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step,
	input wire logic irq_req,
	input wire logic cpu_halt,
	input wire logic reset_req,
	input wire logic [15:0] reset_vector,
	output logic cpu_instr_done,
	output logic irq_pending,
	output logic [15:0] pc
);
	timeunit 1ns;
	timeprecision 1ns;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_instr_done <= 1'b0;
			irq_pending <= 1'b0;
			pc <= 16'h0000;
		end else begin
			// A halted core retires nothing, so the PC freezes in idle
			cpu_instr_done <= step && !cpu_halt;
			irq_pending <= irq_req;
			if (reset_req)
				pc <= reset_vector;
			else if (cpu_instr_done)
				pc <= pc + 16'h0001;
		end
	end
endmodule // pmc_cpu_model

`default_nettype wire

//--- verification/cpu_power_mode_control_tb.sv
// Self-checking bench for the power-mode controller.
// Assumes one AHB-Lite master (this bench) and the core model beside it.
`default_nettype none

module cpu_power_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, done, irq_p, ext_reset = 1'b0, wd_reset = 1'b0;
	logic clk_seen = 1'b0, wake_event = 1'b0, step = 1'b0, irq_req = 1'b0;
	logic cpu_halt, periph_halt, hold, osc_stop, wd_run, mcd_run, reset_req, wake;
	int wake_cnt = 0;
	logic [15:0] vec, pc, pc_save;
	logic [31:0] rd;
	int err_count = 0, num_checks = 0, cycles = 0;
	localparam logic [31:0] PC_A = 32'(pmc_pkg::POWER_CONTROL_ADDR);
	localparam logic [31:0] CF_A = 32'(pmc_pkg::CONFIG_ADDR);

	always #20 hclk = ~hclk;

	// Resume pulses counted at the falling edge, where they are settled
	always @(negedge hclk) begin
		if (wake === 1'b1) wake_cnt++;
	end

	pmc_power_ctrl pmc_power_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cpu_instr_done(done), .irq_pending(irq_p), .ext_reset(ext_reset),
		.watchdog_reset(wd_reset), .clk_seen(clk_seen), .wake_event(wake_event),
		.cpu_halt(cpu_halt), .idle_wake(wake), .periph_halt(periph_halt),
		.irq_timer_hold(hold), .osc_stop(osc_stop), .watchdog_run(wd_run),
		.mcd_run(mcd_run), .reset_req(reset_req), .reset_vector(vec));

	pmc_cpu_model pmc_cpu_model_inst (.hclk(hclk), .hresetn(hresetn), .step(step),
		.irq_req(irq_req), .cpu_halt(cpu_halt), .reset_req(reset_req),
		.reset_vector(vec), .cpu_instr_done(done), .irq_pending(irq_p), .pc(pc));

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Address phase, then data phase; each held until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// One retired instruction, then time for the mode change to land
	task automatic retire();
		@(posedge hclk);
		step <= 1'b1;
		@(posedge hclk);
		step <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
	endtask

	task automatic pulse_reset(input logic wd);
		@(posedge hclk);
		if (wd) wd_reset <= 1'b1;
		else ext_reset <= 1'b1;
		@(posedge hclk);
		wd_reset <= 1'b0;
		ext_reset <= 1'b0;
		while (cpu_halt !== 1'b0) @(posedge hclk);
		repeat (3) @(posedge hclk);
		#1;
	endtask

	task automatic test_reset_values();
		ahb(1'b0, PC_A, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, CF_A, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b1, 32'h0, 32'hff);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		chk({hresp, wd_run, mcd_run}, 32'h2);
	endtask

	task automatic test_idle_irq();
		retire();
		ahb(1'b1, PC_A, 32'h01);
		ahb(1'b0, PC_A, 32'h0);
		chk(rd, 32'h0);
		retire();
		pc_save = pc;
		chk({cpu_halt, periph_halt, osc_stop, hold}, 32'h8);
		chk({wd_run, hreadyout}, 32'h3);
		repeat (5) @(posedge hclk);
		chk(pc, pc_save);
		irq_req <= 1'b1;
		while (cpu_halt !== 1'b0) @(posedge hclk);
		irq_req <= 1'b0;
		chk(pc, pc_save);
		retire();
		chk(pc, pc_save + 16'h1);
		chk(wake_cnt, 32'h1);
	endtask

	task automatic test_idle_reset(input logic wd);
		ahb(1'b1, PC_A, 32'h01);
		retire();
		chk(cpu_halt, 1'b1);
		pulse_reset(wd);
		chk({pc, 15'h0, cpu_halt}, 32'h0);
		ahb(1'b0, PC_A, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic test_stop();
		ahb(1'b1, PC_A, 32'h03);
		ahb(1'b0, PC_A, 32'h0);
		chk(rd, 32'h2);
		chk(cpu_halt, 1'b0);
		retire();
		chk({cpu_halt, periph_halt, osc_stop, hold, wd_run}, 32'h1e);
		irq_req <= 1'b1;
		wake_event <= 1'b1;
		repeat (20) @(posedge hclk);
		#1;
		chk(cpu_halt, 1'b1);
		irq_req <= 1'b0;
		wake_event <= 1'b0;
		pulse_reset(1'b0);
		chk({pc, 13'h0, osc_stop, periph_halt, cpu_halt}, 32'h0);
	endtask

	task automatic test_clock_loss();
		ahb(1'b1, CF_A, 32'h03);
		@(posedge hclk);
		#1;
		chk(mcd_run, 1'b1);
		ahb(1'b1, PC_A, 32'h02);
		retire();
		chk(osc_stop, 1'b1);
		while (cpu_halt !== 1'b0) @(posedge hclk);
		repeat (2) @(posedge hclk);
		chk(pc, 16'h0);
		ahb(1'b1, CF_A, 32'h00);
		ahb(1'b0, CF_A, 32'h0);
		chk(rd, 32'h0);
		chk(wd_run, 1'b0);
	endtask

	task automatic test_suspend();
		// zero-tempco enable is firmware's duty, in a register outside this block
		ahb(1'b1, CF_A, 32'h05);
		while (osc_stop !== 1'b1) @(posedge hclk);
		chk(cpu_halt, 1'b1);
		repeat (10) @(posedge hclk);
		chk(osc_stop, 1'b1);
		wake_event <= 1'b1;
		while (osc_stop !== 1'b0) @(posedge hclk);
		wake_event <= 1'b0;
		@(posedge hclk);
		chk(cpu_halt, 1'b0);
	endtask

	// Longest path is the clock-loss wait of 2500 cycles
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 12000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset_values();
		test_idle_irq();
		test_idle_reset(1'b0);
		test_idle_reset(1'b1);
		test_stop();
		test_clock_loss();
		test_suspend();
		final_report();
	end
endmodule // cpu_power_mode_control_tb

`default_nettype wire
